// ==== bcc_bank.sv ====
// module: register bank for two converter cores and the version register
`timescale 1ns/1ps
module bcc_bank #(
   parameter logic [7:0] VERSION_CODE = bcc_pkg::VERSION_CODE_DEFAULT
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic enable_pin_a,
   input wire logic enable_pin_b,
   output logic [1:0] core_run,
   output logic [1:0] core_use_floor,
   output logic [1:0] core_discharge,
   output logic [1:0] core_forced_pulse_width,
   output logic [2:0] core0_current_limit,
   output logic [2:0] core0_ramp_speed,
   output logic [2:0] core1_current_limit,
   output logic [2:0] core1_ramp_speed
);
   typedef struct packed {
      logic [7:0] c0a;
      logic [7:0] c0b;
      logic [7:0] c1a;
      logic [7:0] c1b;
      logic [1:0] pa_sync;
      logic [1:0] pb_sync;
      logic [7:0] rdata;
   } bcc_state_s;

   bcc_state_s st_q;
   bcc_state_s st_d;
   bcc_core_if cif0 ();
   bcc_core_if cif1 ();

   always_comb begin
      st_d = st_q;
      // pins are asynchronous: two flops before any use
      st_d.pa_sync = {st_q.pa_sync[0], enable_pin_a};
      st_d.pb_sync = {st_q.pb_sync[0], enable_pin_b};
      if (reg_wr) begin
         // reserved bits hold zero; the version register ignores writes
         if (reg_addr == bcc_pkg::ADDR_CORE0_A) begin
            st_d.c0a = reg_wdata & bcc_pkg::CTRL_A_WMASK;
         end else if (reg_addr == bcc_pkg::ADDR_CORE0_B) begin
            st_d.c0b = reg_wdata & bcc_pkg::CTRL_B_WMASK;
         end else if (reg_addr == bcc_pkg::ADDR_CORE1_A) begin
            st_d.c1a = reg_wdata & bcc_pkg::CTRL_A_WMASK;
         end else if (reg_addr == bcc_pkg::ADDR_CORE1_B) begin
            st_d.c1b = reg_wdata & bcc_pkg::CTRL_B_WMASK;
         end
      end
      if (reg_rd) begin
         if (reg_addr == bcc_pkg::ADDR_VERSION) begin
            st_d.rdata = VERSION_CODE;
         end else if (reg_addr == bcc_pkg::ADDR_CORE0_A) begin
            st_d.rdata = st_q.c0a;
         end else if (reg_addr == bcc_pkg::ADDR_CORE0_B) begin
            st_d.rdata = st_q.c0b;
         end else if (reg_addr == bcc_pkg::ADDR_CORE1_A) begin
            st_d.rdata = st_q.c1a;
         end else if (reg_addr == bcc_pkg::ADDR_CORE1_B) begin
            st_d.rdata = st_q.c1b;
         end else begin
            st_d.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q.c0a <= bcc_pkg::CORE0_A_RESET;
         st_q.c0b <= bcc_pkg::CTRL_B_RESET;
         st_q.c1a <= bcc_pkg::CORE1_A_RESET;
         st_q.c1b <= bcc_pkg::CTRL_B_RESET;
         st_q.pa_sync <= 2'h0;
         st_q.pb_sync <= 2'h0;
         st_q.rdata <= 8'h00;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign cif0.ctrl_a = st_q.c0a;
   assign cif0.ctrl_b = st_q.c0b;
   assign cif0.pin_a = st_q.pa_sync[1];
   assign cif0.pin_b = st_q.pb_sync[1];
   assign cif1.ctrl_a = st_q.c1a;
   assign cif1.ctrl_b = st_q.c1b;
   assign cif1.pin_a = st_q.pa_sync[1];
   assign cif1.pin_b = st_q.pb_sync[1];

   bcc_core_ctrl u_core0 (.cif(cif0.core));
   bcc_core_ctrl u_core1 (.cif(cif1.core));

   assign reg_rdata = st_q.rdata;
   assign core_run = {cif1.run, cif0.run};
   assign core_use_floor = {cif1.use_floor, cif0.use_floor};
   assign core_discharge = {cif1.discharge, cif0.discharge};
   assign core_forced_pulse_width = {cif1.forced_pwm, cif0.forced_pwm};
   assign core0_current_limit = cif0.current_limit;
   assign core0_ramp_speed = cif0.ramp_speed;
   assign core1_current_limit = cif1.current_limit;
   assign core1_ramp_speed = cif1.ramp_speed;

   // reference pin levels from the synchroniser, kept apart from the core decode
   logic sp0;
   logic sp1;
   assign sp0 = st_q.c0a[bcc_pkg::BIT_PIN_CHOICE] ? st_q.pb_sync[1] : st_q.pa_sync[1];
   assign sp1 = st_q.c1a[bcc_pkg::BIT_PIN_CHOICE] ? st_q.pb_sync[1] : st_q.pa_sync[1];

   chk_core_on_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
      !st_q.c0a[bcc_pkg::BIT_ON] |-> !core_run[0])
      else $error("core0 runs with enable bit clear");
   chk_pin_gating_and: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c0a[7:6] == 2'h3 && !st_q.c0a[4]) |-> core_run[0] == sp0)
      else $error("core0 gating does not follow selected pin");
   chk_ungated_run: assert property (@(posedge core_clk) disable iff (!rst_b)
      !st_q.c1a[6] |-> core_run[1] == st_q.c1a[7])
      else $error("core1 ungated run mismatch");
   chk_pin_choice_b: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c0a[7:4] == 4'hE) |-> core_run[0] == st_q.pb_sync[1])
      else $error("core0 pin b not selected");
   chk_floor_select: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c0a[6] && st_q.c0a[4]) |-> core_use_floor[0] == !sp0)
      else $error("core0 floor select wrong");
   chk_toggle_stays_on: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c0a[7:6] == 2'h3 && st_q.c0a[4]) |-> core_run[0])
      else $error("core0 dropped in roof/floor mode");
   chk_discharge_off: assert property (@(posedge core_clk) disable iff (!rst_b)
      core_discharge[0] == (st_q.c0a[3]
         && !(st_q.c0a[7] && (!st_q.c0a[6] || st_q.c0a[4] || sp0))))
      else $error("core0 discharge wrong");
   chk_forced_pwm_wr: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_CORE1_A)
      |=> core_forced_pulse_width[1] == $past(reg_wdata[1]))
      else $error("core1 forced mode not applied");
   chk_limit_live: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_CORE0_B)
      |=> core0_current_limit == $past(reg_wdata[5:3]))
      else $error("core0 limit not applied next cycle");
   chk_ramp_live: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_CORE1_B)
      |=> core1_ramp_speed == $past(reg_wdata[2:0]))
      else $error("core1 ramp not applied");
   chk_version_read: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_rd && reg_addr == bcc_pkg::ADDR_VERSION) |=> reg_rdata == VERSION_CODE)
      else $error("version read wrong");
   chk_core1_on_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
      !st_q.c1a[bcc_pkg::BIT_ON] |-> !core_run[1])
      else $error("core1 runs with enable bit clear");
   chk_core1_gating: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c1a[7:6] == 2'h3 && !st_q.c1a[4]) |-> core_run[1] == sp1)
      else $error("core1 gating does not follow selected pin");
   chk_core1_floor: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c1a[6] && st_q.c1a[4]) |-> core_use_floor[1] == !sp1)
      else $error("core1 floor select wrong");
   chk_core1_discharge: assert property (@(posedge core_clk) disable iff (!rst_b)
      core_discharge[1] == (st_q.c1a[3]
         && !(st_q.c1a[7] && (!st_q.c1a[6] || st_q.c1a[4] || sp1))))
      else $error("core1 discharge wrong");
   chk_pin_choice_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c0a[7:4] == 4'hC) |-> core_run[0] == st_q.pa_sync[1])
      else $error("core0 pin a not selected");
   chk_floor_needs_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
      !(st_q.c0a[6] && st_q.c0a[4]) |-> !core_use_floor[0])
      else $error("core0 floor select outside roof/floor mode");
   chk_forced_pwm_core0: assert property (@(posedge core_clk) disable iff (!rst_b)
      core_forced_pulse_width[0] == st_q.c0a[bcc_pkg::BIT_FORCED_PWM])
      else $error("core0 forced mode does not follow its bit");
   chk_ctrl_a_write: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_CORE0_A)
      |=> st_q.c0a == ($past(reg_wdata) & bcc_pkg::CTRL_A_WMASK))
      else $error("core0 control A write not stored");
   chk_limit_core1: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_CORE1_B)
      |=> core1_current_limit == $past(reg_wdata[5:3]))
      else $error("core1 limit not applied next cycle");
   chk_ramp_core0: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_CORE0_B)
      |=> core0_ramp_speed == $past(reg_wdata[2:0]))
      else $error("core0 ramp not applied");
   chk_reserved_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_q.c0b[7:6] | st_q.c1b[7:6]) == 2'h0)
      else $error("reserved control B bits set");
   // the version register has no storage, so a write there must touch nothing
   chk_version_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_VERSION)
      |=> $stable(st_q.c0a) && $stable(st_q.c0b) && $stable(st_q.c1a) && $stable(st_q.c1b))
      else $error("version write disturbed a control register");
   chk_ctrl_a_read: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_rd && reg_addr == bcc_pkg::ADDR_CORE0_A)
      |=> reg_rdata == $past(st_q.c0a))
      else $error("core0 control A read wrong");
   chk_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clk_en && reg_rd && (reg_addr == 8'h00 || reg_addr > bcc_pkg::ADDR_CORE1_B))
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
      !(clk_en && reg_rd) |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   chk_freeze_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
      !clk_en |=> $stable(st_q))
      else $error("state moved while clock enable low");
   cov_write_core0: cover property (@(posedge core_clk) disable iff (!rst_b)
      clk_en && reg_wr && reg_addr == bcc_pkg::ADDR_CORE0_A);
   cov_floor_used: cover property (@(posedge core_clk) disable iff (!rst_b) core_use_floor[0]);
   cov_pin_stop: cover property (@(posedge core_clk) disable iff (!rst_b)
      core_run[0] ##1 !core_run[0]);
   cov_pin_b_run: cover property (@(posedge core_clk) disable iff (!rst_b)
      st_q.c1a[6:5] == 2'h3 && core_run[1]);
   cov_frozen_write: cover property (@(posedge core_clk) disable iff (!rst_b)
      !clk_en && reg_wr);
endmodule : bcc_bank

// ==== bcc_pkg.sv ====
// package: register map, field layout and reset values of the buck core control bank
package bcc_pkg;
   localparam logic [7:0] ADDR_VERSION = 8'h01;
   localparam logic [7:0] ADDR_CORE0_A = 8'h02;
   localparam logic [7:0] ADDR_CORE0_B = 8'h03;
   localparam logic [7:0] ADDR_CORE1_A = 8'h04;
   localparam logic [7:0] ADDR_CORE1_B = 8'h05;
   localparam int BIT_ON = 7;
   localparam int BIT_PIN_GATING = 6;
   localparam int BIT_PIN_CHOICE = 5;
   localparam int BIT_TOGGLE_MODE = 4;
   localparam int BIT_DISCHARGE = 3;
   localparam int BIT_FORCED_PWM = 1;
   localparam int LIM_LSB = 3;
   localparam int RAMP_LSB = 0;
   localparam logic [7:0] CTRL_A_WMASK = 8'hFA;
   localparam logic [7:0] CTRL_B_WMASK = 8'h3F;
   localparam logic [7:0] CORE0_A_RESET = 8'hC8;
   localparam logic [7:0] CORE1_A_RESET = 8'hC8;
   localparam logic [7:0] CTRL_B_RESET = 8'h34;
   localparam logic [2:0] LIM_MIN_CODE = 3'h2;
   // arbitrary neutral value, not a real part's code
   localparam logic [7:0] VERSION_CODE_DEFAULT = 8'h5A;
endpackage : bcc_pkg

// ==== bcc_core_if.sv ====
// interface: control fields and pin levels for one converter core
`timescale 1ns/1ps
interface bcc_core_if;
   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic pin_a;
   logic pin_b;
   logic run;
   logic use_floor;
   logic discharge;
   logic forced_pwm;
   logic [2:0] current_limit;
   logic [2:0] ramp_speed;
   modport bank (output ctrl_a, output ctrl_b, output pin_a, output pin_b,
      input run, input use_floor, input discharge, input forced_pwm,
      input current_limit, input ramp_speed);
   modport core (input ctrl_a, input ctrl_b, input pin_a, input pin_b,
      output run, output use_floor, output discharge, output forced_pwm,
      output current_limit, output ramp_speed);
endinterface : bcc_core_if

// ==== bcc_core_ctrl.sv ====
// module: decode of one core's control fields into run, voltage and mode levels
`timescale 1ns/1ps
module bcc_core_ctrl (
   bcc_core_if.core cif
);
   logic gating;
   logic pin_lvl;
   always_comb begin
      gating = cif.ctrl_a[bcc_pkg::BIT_PIN_GATING];
      pin_lvl = cif.ctrl_a[bcc_pkg::BIT_PIN_CHOICE] ? cif.pin_b : cif.pin_a;
      // roof/floor mode keeps the core on; the pin only picks the target
      if (!gating) begin
         cif.run = cif.ctrl_a[bcc_pkg::BIT_ON];
         cif.use_floor = 1'b0;
      end else if (cif.ctrl_a[bcc_pkg::BIT_TOGGLE_MODE]) begin
         cif.run = cif.ctrl_a[bcc_pkg::BIT_ON];
         cif.use_floor = !pin_lvl;
      end else begin
         cif.run = cif.ctrl_a[bcc_pkg::BIT_ON] && pin_lvl;
         cif.use_floor = 1'b0;
      end
      cif.discharge = cif.ctrl_a[bcc_pkg::BIT_DISCHARGE] && !cif.run;
      cif.forced_pwm = cif.ctrl_a[bcc_pkg::BIT_FORCED_PWM];
      // live code, applied without stopping the core
      cif.current_limit = cif.ctrl_b[bcc_pkg::LIM_LSB +: 3];
      cif.ramp_speed = cif.ctrl_b[bcc_pkg::RAMP_LSB +: 3];
   end
endmodule : bcc_core_ctrl

// ==== buck_core_control_registers_tb.sv ====
// testbench: self-checking bench for the buck core control register bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("Error %0t: got %h expected %h", $time, g, e); end end
module buck_core_control_registers_tb;
   localparam logic [7:0] VER = 8'hA7; // arbitrary value, not a real part's code
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic enable_pin_a = 1'b0;
   logic enable_pin_b = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] core_run, core_use_floor, core_discharge, core_forced_pulse_width;
   logic [2:0] core0_current_limit, core0_ramp_speed, core1_current_limit, core1_ramp_speed;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   bcc_bank #(.VERSION_CODE(VER)) bcc_bank_inst (.core_clk(core_clk), .rst_b(rst_b),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable_pin_a(enable_pin_a),
      .enable_pin_b(enable_pin_b), .core_run(core_run), .core_use_floor(core_use_floor),
      .core_discharge(core_discharge), .core_forced_pulse_width(core_forced_pulse_width),
      .core0_current_limit(core0_current_limit), .core0_ramp_speed(core0_ramp_speed),
      .core1_current_limit(core1_current_limit), .core1_ramp_speed(core1_ramp_speed));

   always #12.5 core_clk = ~core_clk;

   task automatic conclude();
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // whole run needs well under 1000 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      `CHK(reg_rdata, e)
   endtask : rd

   // three edges cover the two-flop synchroniser
   task automatic pins(input logic a, input logic b);
      @(negedge core_clk);
      enable_pin_a = a;
      enable_pin_b = b;
      repeat (3) @(negedge core_clk);
   endtask : pins

   task automatic t_reset();
      rd(bcc_pkg::ADDR_VERSION, VER);
      rd(bcc_pkg::ADDR_CORE0_A, 8'hC8);
      rd(bcc_pkg::ADDR_CORE0_B, 8'h34);
      rd(bcc_pkg::ADDR_CORE1_A, 8'hC8);
      rd(bcc_pkg::ADDR_CORE1_B, 8'h34);
      rd(8'h06, 8'h00);
      `CHK(core_run, 2'b00)
      `CHK(core_discharge, 2'b11)
      `CHK(core0_current_limit, 3'h6)
      `CHK(core1_ramp_speed, 3'h4)
      `CHK(core_forced_pulse_width, 2'b00)
      `CHK(core_use_floor, 2'b00)
      wr(bcc_pkg::ADDR_VERSION, 8'h00);
      rd(bcc_pkg::ADDR_VERSION, VER);
   endtask : t_reset

   task automatic t_gating();
      pins(1'b1, 1'b0);
      `CHK(core_run, 2'b11)
      `CHK(core_discharge, 2'b00)
      pins(1'b0, 1'b1);
      `CHK(core_run, 2'b00)
      wr(bcc_pkg::ADDR_CORE1_A, 8'hE8);
      `CHK(core_run, 2'b10)
      wr(bcc_pkg::ADDR_CORE0_A, 8'h88);
      pins(1'b0, 1'b0);
      `CHK(core_run, 2'b01)
      `CHK(core_discharge, 2'b10)
      wr(bcc_pkg::ADDR_CORE0_A, 8'h08);
      `CHK(core_run[0], 1'b0)
      `CHK(core_discharge[0], 1'b1)
      wr(bcc_pkg::ADDR_CORE0_A, 8'h00);
      `CHK(core_discharge[0], 1'b0)
      wr(bcc_pkg::ADDR_CORE0_A, 8'hD8);
      `CHK(core_run[0], 1'b1)
      `CHK(core_use_floor[0], 1'b1)
      pins(1'b1, 1'b0);
      `CHK(core_use_floor[0], 1'b0)
      `CHK(core_run[0], 1'b1)
      wr(bcc_pkg::ADDR_CORE0_A, 8'hFF);
      `CHK(core_forced_pulse_width[0], 1'b1)
      rd(bcc_pkg::ADDR_CORE0_A, 8'hFA);
      wr(bcc_pkg::ADDR_CORE0_A, 8'hE8);
      `CHK(core_run[0], 1'b0)
      wr(bcc_pkg::ADDR_CORE0_A, 8'hC8);
      `CHK(core_forced_pulse_width[0], 1'b0)
      `CHK(core_run[0], 1'b1)
   endtask : t_gating

   task automatic t_fields();
      logic [2:0] c;
      for (int k = 0; k < 8; k++) begin
         c = 3'(k);
         wr(bcc_pkg::ADDR_CORE0_B, {2'b11, c, c});
         `CHK(core0_current_limit, c)
         `CHK(core0_ramp_speed, c)
         `CHK(core_run[0], 1'b1)
         rd(bcc_pkg::ADDR_CORE0_B, {2'b00, c, c});
         wr(bcc_pkg::ADDR_CORE1_B, {2'b00, ~c, c});
         `CHK(core1_current_limit, ~c)
         `CHK(core1_ramp_speed, c)
      end
      wr(bcc_pkg::ADDR_CORE1_A, 8'hF2);
      `CHK(core_use_floor[1], 1'b1)
      `CHK(core_run[1], 1'b1)
      `CHK(core_forced_pulse_width[1], 1'b1)
   endtask : t_fields

   // a write while the clock enable is low must leave the register alone
   task automatic t_freeze();
      @(negedge core_clk);
      clk_en = 1'b0;
      wr(bcc_pkg::ADDR_CORE0_A, 8'h00);
      clk_en = 1'b1;
      rd(bcc_pkg::ADDR_CORE0_A, 8'hC8);
   endtask : t_freeze

   initial begin
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      t_reset();
      t_gating();
      t_fields();
      t_freeze();
      conclude();
   end
endmodule : buck_core_control_registers_tb
